// file: pkg/bff_pkg.sv
package bff_pkg;
  // register word offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FRAME_CFG = 8'h08;
  localparam logic [7:0] OFF_SUPERFRAME = 8'h0C;
  localparam logic [7:0] OFF_BSN = 8'h10;
  localparam logic [7:0] OFF_PAN_SHORT = 8'h14;
  localparam logic [7:0] OFF_EXT_LO = 8'h18;
  localparam logic [7:0] OFF_EXT_HI = 8'h1C;
  localparam logic [7:0] OFF_GTS_BASE = 8'h20;
  localparam int GTS_SLOTS = 7;
  // reset values
  localparam logic [31:0] FRAME_CFG_RST = 32'h0000_0002;
  localparam logic [31:0] SUPERFRAME_RST = 32'h0000_0FFF;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [23:0] GTS_RST = 24'h00_0000;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // frame constants
  localparam logic [2:0] FT_BEACON = 3'h0;
  localparam logic [1:0] AM_SHORT = 2'h2;
  localparam logic [1:0] AM_EXT = 2'h3;
  localparam logic [3:0] SEC_LEN_MAX = 4'hE;
  localparam logic [3:0] MIN_FINAL_CAP_SLOT = 4'h8;
  localparam logic [2:0] PEND_ADDR_MAX = 3'h7;
  // control and status bits
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_RXCLR_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RXGOOD_BIT = 1;
  localparam int STAT_RXBAD_BIT = 2;
  localparam int STAT_BSN_LSB = 8;
  localparam int STAT_FT_LSB = 16;
  localparam int STAT_FPEND_BIT = 19;
  localparam int STAT_SRCM_LSB = 20;
  // frame configuration fields
  localparam int CFG_SRCM_LSB = 0;
  localparam int CFG_SECEN_BIT = 2;
  localparam int CFG_VER_LSB = 3;
  localparam int CFG_BPEND_BIT = 5;
  localparam int CFG_SECLEN_LSB = 6;
  localparam int CFG_PSHORT_LSB = 10;
  localparam int CFG_PEXT_LSB = 13;
  localparam int CFG_PAY_BIT = 16;
  // superframe configuration fields
  localparam int SF_BO_LSB = 0;
  localparam int SF_SO_LSB = 4;
  localparam int SF_CAP_LSB = 8;
  localparam int SF_BLE_BIT = 12;
  localparam int SF_PANC_BIT = 14;
  localparam int SF_ASSOC_BIT = 15;
  localparam int SF_GPERMIT_BIT = 16;
  localparam int SF_GCNT_LSB = 17;
  localparam int SF_GDIR_LSB = 20;
  typedef enum logic [3:0] {
    ST_IDLE, ST_FC, ST_SEQ, ST_PAN, ST_ADDR, ST_SEC, ST_SF, ST_GSPEC,
    ST_GDIR, ST_GLIST, ST_PSPEC, ST_PLIST, ST_PAY, ST_FCS, ST_DONE
  } bff_tx_state_e;
endpackage

// file: rtl/bff_framer.sv
`timescale 1ns/1ps
// Operation
// [R1] a 16-bit check over header and payload closes every frame
// [R2] remainder of message times x^16 divided by x^16+x^12+x^5+1
// [R3] remainder cleared before each frame; bits enter lsb of each octet first
// [R4] remainder after last payload bit is the check value, unaltered
// [R5] check value follows payload, r0 sent first, r15 last
// [R6] beacon type, source mode; security flag only if enabled and version nonzero
// [R7] pending bit from queued broadcast; other control bits zero, ignored on receive
// [R8] sequence octet is the current beacon sequence counter
// [R9] only source pan id and own address, 4 or 10 octets
// [R10] fixed octet order from frame control to check value
// [R11] superframe spec bit layout with reserved bit 13 zero
// [R12] final cap slot kept at or above minimum unless descriptors present
// [R13] battery life extension bit follows its configuration
// [R14] pan coordinator bit set only by the pan coordinator
// [R15] association permit bit mirrors the permit attribute
// [R16] gts spec: count bits 0-2, zero 3-6, permit bit 7
// [R17] zero descriptor count omits directions and list
// [R18] directions mask bits 0-6, first descriptor lowest, bit 7 zero
// [R19] at most seven descriptors, three octets each
// [R20] descriptor: short address, start slot, length, low octet first
// [R21] pending part is one spec octet then the address list
// [R22] frame type in control bits 0-2, beacon is 000
// [R23] pending spec: short count 0-2, extended count 4-6, bits 3,7 zero
// [R24] at most seven pending addresses, short ones first
// [R25] received check recomputed and mismatch flags the frame bad
module bff_framer (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] tx_in_data,
  input wire logic tx_in_valid,
  input wire logic tx_in_last,
  output logic tx_in_ready,
  output logic tx_bit,
  output logic tx_bit_valid,
  output logic tx_frame_end,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic rx_frame_end
);

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    logic fb;
    fb = b ^ c[15];
    crc_step = {c[14:0], 1'b0} ^ (fb ? bff_pkg::CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
    begin
      rev8[i] = v[7 - i];
    end
  endfunction

  logic [31:0] cfg_reg, sf_reg, pan_short_reg, ext_lo_reg, ext_hi_reg;
  logic [7:0] bsn_reg;
  logic [23:0] gts_mem [0:bff_pkg::GTS_SLOTS-1];
  bff_pkg::bff_tx_state_e st_reg, st_next;
  logic [5:0] cnt_reg, field_len;
  logic [7:0] shreg_reg, octet_w;
  logic [3:0] bits_left_reg;
  logic oct_crc_reg;
  logic [15:0] crc_reg, fcs_reg;
  logic tx_bit_reg, tx_valid_reg, tx_end_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic [15:0] rx_crc_reg;
  logic [7:0] rx_sh_reg, rx_bsn_reg;
  logic [2:0] rx_bitcnt_reg, rx_ft_reg;
  logic [1:0] rx_octcnt_reg, rx_srcm_reg;
  logic rx_fpend_reg, rx_good_reg, rx_bad_reg;

  // register write decode
  wire wr_ctrl = reg_wr && reg_addr == bff_pkg::OFF_CTRL;
  wire start_acc = wr_ctrl && reg_wdata[bff_pkg::CTRL_START_BIT] && st_reg == bff_pkg::ST_IDLE;
  wire rx_clr = wr_ctrl && reg_wdata[bff_pkg::CTRL_RXCLR_BIT];

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_reg <= bff_pkg::FRAME_CFG_RST;
      sf_reg <= bff_pkg::SUPERFRAME_RST;
      bsn_reg <= bff_pkg::WORD_RST[7:0];
      pan_short_reg <= bff_pkg::WORD_RST;
      ext_lo_reg <= bff_pkg::WORD_RST;
      ext_hi_reg <= bff_pkg::WORD_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == bff_pkg::OFF_FRAME_CFG)
        cfg_reg <= reg_wdata;
      else if (reg_addr == bff_pkg::OFF_SUPERFRAME)
        sf_reg <= reg_wdata;
      else if (reg_addr == bff_pkg::OFF_BSN)
        bsn_reg <= reg_wdata[7:0];
      else if (reg_addr == bff_pkg::OFF_PAN_SHORT)
        pan_short_reg <= reg_wdata;
      else if (reg_addr == bff_pkg::OFF_EXT_LO)
        ext_lo_reg <= reg_wdata;
      else if (reg_addr == bff_pkg::OFF_EXT_HI)
        ext_hi_reg <= reg_wdata;
    end
  end

  for (genvar g = 0; g < bff_pkg::GTS_SLOTS; g++)
  begin : g_gts
    always_ff @(posedge sys_clk or posedge reset)
    begin
      if (reset)
        gts_mem[g] <= bff_pkg::GTS_RST;
      else if (reg_wr && reg_addr == bff_pkg::OFF_GTS_BASE + 8'(4 * g))
        gts_mem[g] <= reg_wdata[23:0];
    end
  end

  // frame fields derived from configuration
  wire src_ext = cfg_reg[bff_pkg::CFG_SRCM_LSB +: 2] == bff_pkg::AM_EXT; // R9
  wire [1:0] fver = cfg_reg[bff_pkg::CFG_VER_LSB +: 2];
  wire sec_flag = cfg_reg[bff_pkg::CFG_SECEN_BIT] && fver != 2'h0; // R6
  wire [3:0] sec_raw = cfg_reg[bff_pkg::CFG_SECLEN_LSB +: 4];
  wire [3:0] sec_len = !sec_flag ? 4'h0 : (sec_raw > bff_pkg::SEC_LEN_MAX ? bff_pkg::SEC_LEN_MAX : sec_raw);
  wire [2:0] gcnt = sf_reg[bff_pkg::SF_GCNT_LSB +: 3]; // R19
  wire [6:0] gdir = sf_reg[bff_pkg::SF_GDIR_LSB +: 7];
  wire gpermit = sf_reg[bff_pkg::SF_GPERMIT_BIT];
  wire [2:0] pshort = cfg_reg[bff_pkg::CFG_PSHORT_LSB +: 3];
  wire [2:0] pext_raw = cfg_reg[bff_pkg::CFG_PEXT_LSB +: 3];
  // extended entries are dropped first, so short ones always stay in the list
  wire [2:0] pext = ({1'b0, pshort} + {1'b0, pext_raw} > {1'b0, bff_pkg::PEND_ADDR_MAX}) ?
                    3'(bff_pkg::PEND_ADDR_MAX - pshort) : pext_raw; // R24
  wire pay_present = cfg_reg[bff_pkg::CFG_PAY_BIT];
  wire [3:0] cap_raw = sf_reg[bff_pkg::SF_CAP_LSB +: 4];
  wire [3:0] final_cap = (gcnt == 3'h0 && cap_raw < bff_pkg::MIN_FINAL_CAP_SLOT) ?
                         bff_pkg::MIN_FINAL_CAP_SLOT : cap_raw; // R12
  wire [15:0] sf_spec = {sf_reg[bff_pkg::SF_ASSOC_BIT], sf_reg[bff_pkg::SF_PANC_BIT], 1'b0,
                         sf_reg[bff_pkg::SF_BLE_BIT], final_cap, sf_reg[bff_pkg::SF_SO_LSB +: 4],
                         sf_reg[bff_pkg::SF_BO_LSB +: 4]}; // R11 R13 R14 R15
  // version is sent as configured so a receiver can interpret the security flag
  wire [15:0] fc_word = {src_ext ? bff_pkg::AM_EXT : bff_pkg::AM_SHORT, fver, 2'h0, 3'h0, 1'b0, 1'b0,
                         cfg_reg[bff_pkg::CFG_BPEND_BIT], sec_flag, bff_pkg::FT_BEACON}; // R6 R7 R22
  wire [63:0] ext_addr = {ext_hi_reg, ext_lo_reg};
  wire [2:0] gdesc = 3'(cnt_reg / 6'd3);
  wire [1:0] gbyte = 2'(cnt_reg % 6'd3);
  wire [23:0] gts_cur = gts_mem[gdesc];

  // serializer and divider
  wire [15:0] crc_next = (bits_left_reg != 4'h0 && oct_crc_reg) ? crc_step(crc_reg, shreg_reg[0]) : crc_reg; // R2
  wire busy_st = st_reg != bff_pkg::ST_IDLE && st_reg != bff_pkg::ST_DONE;
  wire stream_st = st_reg == bff_pkg::ST_SEC || st_reg == bff_pkg::ST_PLIST || st_reg == bff_pkg::ST_PAY;
  wire load_ok = busy_st && bits_left_reg <= 4'h1 && (!stream_st || tx_in_valid);
  wire field_done = (st_reg == bff_pkg::ST_PAY) ? tx_in_last : (cnt_reg == field_len - 6'd1);

  always_comb
  begin
    case (st_reg)
      bff_pkg::ST_FC: field_len = 6'd2;
      bff_pkg::ST_PAN: field_len = 6'd2;
      bff_pkg::ST_ADDR: field_len = src_ext ? 6'd8 : 6'd2; // R9
      bff_pkg::ST_SEC: field_len = 6'(sec_len);
      bff_pkg::ST_SF: field_len = 6'd2;
      bff_pkg::ST_GLIST: field_len = 6'(gcnt) * 6'd3; // R19
      bff_pkg::ST_PLIST: field_len = 6'(pshort) * 6'd2 + 6'(pext) * 6'd8;
      bff_pkg::ST_FCS: field_len = 6'd2;
      default: field_len = 6'd1;
    endcase
  end

  always_comb
  begin
    case (st_reg)
      bff_pkg::ST_FC: octet_w = cnt_reg == 6'd0 ? fc_word[7:0] : fc_word[15:8];
      bff_pkg::ST_SEQ: octet_w = bsn_reg; // R8
      bff_pkg::ST_PAN: octet_w = pan_short_reg[8 * cnt_reg[0] +: 8];
      bff_pkg::ST_ADDR: octet_w = src_ext ? ext_addr[8 * cnt_reg[2:0] +: 8] : pan_short_reg[16 + 8 * cnt_reg[0] +: 8];
      bff_pkg::ST_SF: octet_w = sf_spec[8 * cnt_reg[0] +: 8];
      bff_pkg::ST_GSPEC: octet_w = {gpermit, 4'h0, gcnt}; // R16
      bff_pkg::ST_GDIR: octet_w = {1'b0, gdir}; // R18
      bff_pkg::ST_GLIST: octet_w = gts_cur[8 * gbyte +: 8]; // R20
      bff_pkg::ST_PSPEC: octet_w = {1'b0, pext, 1'b0, pshort}; // R21 R23
      bff_pkg::ST_FCS: octet_w = cnt_reg == 6'd0 ? rev8(crc_next[15:8]) : rev8(fcs_reg[7:0]); // R4 R5
      default: octet_w = tx_in_data;
    endcase
  end

  // field order, skipping fields of zero length
  always_comb
  begin
    case (st_reg)
      bff_pkg::ST_FC: st_next = bff_pkg::ST_SEQ;
      bff_pkg::ST_SEQ: st_next = bff_pkg::ST_PAN;
      bff_pkg::ST_PAN: st_next = bff_pkg::ST_ADDR;
      bff_pkg::ST_ADDR: st_next = sec_len != 4'h0 ? bff_pkg::ST_SEC : bff_pkg::ST_SF; // R10
      bff_pkg::ST_SEC: st_next = bff_pkg::ST_SF;
      bff_pkg::ST_SF: st_next = bff_pkg::ST_GSPEC;
      bff_pkg::ST_GSPEC: st_next = gcnt != 3'h0 ? bff_pkg::ST_GDIR : bff_pkg::ST_PSPEC; // R17
      bff_pkg::ST_GDIR: st_next = bff_pkg::ST_GLIST;
      bff_pkg::ST_GLIST: st_next = bff_pkg::ST_PSPEC;
      bff_pkg::ST_PSPEC: st_next = field_len == 6'd0 ? bff_pkg::ST_PAY : bff_pkg::ST_PLIST;
      bff_pkg::ST_PLIST: st_next = pay_present ? bff_pkg::ST_PAY : bff_pkg::ST_FCS;
      bff_pkg::ST_PAY: st_next = bff_pkg::ST_FCS;
      default: st_next = bff_pkg::ST_DONE;
    endcase
  end

  // pspec peeks the list length through a separate term so the skip is exact
  wire [5:0] plist_len = 6'(pshort) * 6'd2 + 6'(pext) * 6'd8;
  wire [3:0] after_pspec_pick = {plist_len != 6'd0, pay_present, 2'h0};
  bff_pkg::bff_tx_state_e st_after;
  always_comb
  begin
    st_after = st_next;
    if (st_reg == bff_pkg::ST_PSPEC)
    begin
      if (after_pspec_pick[3])
        st_after = bff_pkg::ST_PLIST;
      else if (after_pspec_pick[2])
        st_after = bff_pkg::ST_PAY;
      else
        st_after = bff_pkg::ST_FCS;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      st_reg <= bff_pkg::ST_IDLE;
      cnt_reg <= 6'd0;
    end
    else if (st_reg == bff_pkg::ST_IDLE)
    begin
      if (start_acc)
        st_reg <= bff_pkg::ST_FC;
      cnt_reg <= 6'd0;
    end
    else if (st_reg == bff_pkg::ST_DONE)
    begin
      if (bits_left_reg == 4'h0)
        st_reg <= bff_pkg::ST_IDLE;
    end
    else if (load_ok)
    begin
      st_reg <= field_done ? st_after : st_reg;
      cnt_reg <= field_done ? 6'd0 : cnt_reg + 6'd1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      shreg_reg <= 8'h00;
      bits_left_reg <= 4'h0;
      oct_crc_reg <= 1'b0;
    end
    else if (load_ok)
    begin
      shreg_reg <= octet_w;
      bits_left_reg <= 4'h8;
      oct_crc_reg <= st_reg != bff_pkg::ST_FCS; // R1
    end
    else if (bits_left_reg != 4'h0)
    begin
      shreg_reg <= {1'b0, shreg_reg[7:1]}; // R3
      bits_left_reg <= bits_left_reg - 4'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      crc_reg <= bff_pkg::CRC_INIT;
      fcs_reg <= bff_pkg::CRC_INIT;
      tx_bit_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
      tx_end_reg <= 1'b0;
    end
    else
    begin
      crc_reg <= start_acc ? bff_pkg::CRC_INIT : crc_next; // R3
      if (load_ok && st_reg == bff_pkg::ST_FCS && cnt_reg == 6'd0)
        fcs_reg <= crc_next; // R4
      tx_bit_reg <= shreg_reg[0];
      tx_valid_reg <= bits_left_reg != 4'h0;
      tx_end_reg <= st_reg == bff_pkg::ST_DONE && bits_left_reg == 4'h0;
    end
  end

  assign tx_in_ready = load_ok && stream_st;
  assign tx_bit = tx_bit_reg;
  assign tx_bit_valid = tx_valid_reg;
  assign tx_frame_end = tx_end_reg;

  // receive: divider over every bit, check octets included, leaves zero
  wire rx_oct_done = rx_bit_valid && rx_bitcnt_reg == 3'h7;
  wire [7:0] rx_octet = {rx_bit, rx_sh_reg[7:1]};
  wire rx_ok = rx_crc_reg == 16'h0000 && rx_octcnt_reg == 2'h3;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rx_crc_reg <= bff_pkg::CRC_INIT;
      rx_sh_reg <= 8'h00;
      rx_bitcnt_reg <= 3'h0;
      rx_octcnt_reg <= 2'h0;
    end
    else if (rx_frame_end)
    begin
      rx_crc_reg <= bff_pkg::CRC_INIT;
      rx_bitcnt_reg <= 3'h0;
      rx_octcnt_reg <= 2'h0;
    end
    else if (rx_bit_valid)
    begin
      rx_crc_reg <= crc_step(rx_crc_reg, rx_bit); // R25
      rx_sh_reg <= rx_octet;
      rx_bitcnt_reg <= rx_bitcnt_reg + 3'h1;
      if (rx_oct_done && rx_octcnt_reg != 2'h3)
        rx_octcnt_reg <= rx_octcnt_reg + 2'h1;
    end
  end

  // only type, pending and source mode are kept; other control bits are ignored
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rx_ft_reg <= 3'h0;
      rx_fpend_reg <= 1'b0;
      rx_srcm_reg <= 2'h0;
      rx_bsn_reg <= 8'h00;
      rx_good_reg <= 1'b0;
      rx_bad_reg <= 1'b0;
    end
    else
    begin
      if (rx_oct_done && !rx_frame_end && rx_octcnt_reg == 2'h0)
      begin
        rx_ft_reg <= rx_octet[2:0];
        rx_fpend_reg <= rx_octet[4]; // R7
      end
      if (rx_oct_done && !rx_frame_end && rx_octcnt_reg == 2'h1)
        rx_srcm_reg <= rx_octet[7:6];
      if (rx_oct_done && !rx_frame_end && rx_octcnt_reg == 2'h2)
        rx_bsn_reg <= rx_octet;
      // a verdict in the clearing cycle survives the clear
      rx_good_reg <= (rx_frame_end && rx_ok) || (rx_good_reg && !rx_clr);
      rx_bad_reg <= (rx_frame_end && !rx_ok) || (rx_bad_reg && !rx_clr); // R25
    end
  end

  // register read
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (reg_addr == bff_pkg::OFF_STATUS)
    begin
      rdata_next[bff_pkg::STAT_BUSY_BIT] = st_reg != bff_pkg::ST_IDLE;
      rdata_next[bff_pkg::STAT_RXGOOD_BIT] = rx_good_reg;
      rdata_next[bff_pkg::STAT_RXBAD_BIT] = rx_bad_reg;
      rdata_next[bff_pkg::STAT_BSN_LSB +: 8] = rx_bsn_reg;
      rdata_next[bff_pkg::STAT_FT_LSB +: 3] = rx_ft_reg;
      rdata_next[bff_pkg::STAT_FPEND_BIT] = rx_fpend_reg;
      rdata_next[bff_pkg::STAT_SRCM_LSB +: 2] = rx_srcm_reg;
    end
    else if (reg_addr == bff_pkg::OFF_FRAME_CFG)
      rdata_next = cfg_reg;
    else if (reg_addr == bff_pkg::OFF_SUPERFRAME)
      rdata_next = sf_reg;
    else if (reg_addr == bff_pkg::OFF_BSN)
      rdata_next = {24'h00_0000, bsn_reg};
    else if (reg_addr == bff_pkg::OFF_PAN_SHORT)
      rdata_next = pan_short_reg;
    else if (reg_addr == bff_pkg::OFF_EXT_LO)
      rdata_next = ext_lo_reg;
    else if (reg_addr == bff_pkg::OFF_EXT_HI)
      rdata_next = ext_hi_reg;
    else if (reg_addr >= bff_pkg::OFF_GTS_BASE && reg_addr < bff_pkg::OFF_GTS_BASE + 8'(4 * bff_pkg::GTS_SLOTS)
             && reg_addr[1:0] == 2'h0)
      rdata_next = {8'h00, gts_mem[3'((reg_addr - bff_pkg::OFF_GTS_BASE) >> 2)]};
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= reg_rd ? rdata_next : 32'h0000_0000;
  end
  assign reg_rdata = rdata_reg;

  // checks
  wire ld_fc0 = load_ok && st_reg == bff_pkg::ST_FC && cnt_reg == 6'd0;
  wire ld_sf1 = load_ok && st_reg == bff_pkg::ST_SF && cnt_reg == 6'd1;
  wire ld_gspec = load_ok && st_reg == bff_pkg::ST_GSPEC;
  AST_CRC_CLEARED: assert property (@(posedge sys_clk) disable iff (reset) start_acc |=> crc_reg == 16'h0000) // R3
    else $error("divider not cleared at frame start");
  AST_FC_TYPE: assert property (@(posedge sys_clk) disable iff (reset) ld_fc0 |-> octet_w[2:0] == 3'h0) // R22
    else $error("beacon frame type not zero");
  AST_SEC_FLAG: assert property (@(posedge sys_clk) disable iff (reset)
    ld_fc0 |-> octet_w[3] == (cfg_reg[bff_pkg::CFG_SECEN_BIT] && fver != 2'h0)) // R6
    else $error("security flag wrong");
  AST_SEQ_NUM: assert property (@(posedge sys_clk) disable iff (reset)
    load_ok && st_reg == bff_pkg::ST_SEQ |-> octet_w == bsn_reg) // R8
    else $error("sequence octet differs from counter");
  AST_SF_FLAGS: assert property (@(posedge sys_clk) disable iff (reset)
    ld_sf1 |-> octet_w[5] == 1'b0 && octet_w[4] == sf_reg[bff_pkg::SF_BLE_BIT]
    && octet_w[6] == sf_reg[bff_pkg::SF_PANC_BIT] && octet_w[7] == sf_reg[bff_pkg::SF_ASSOC_BIT]) // R11
    else $error("superframe flag octet wrong");
  AST_MIN_CAP: assert property (@(posedge sys_clk) disable iff (reset)
    ld_sf1 && gcnt == 3'h0 |-> octet_w[3:0] >= bff_pkg::MIN_FINAL_CAP_SLOT) // R12
    else $error("final cap slot below minimum");
  AST_GTS_SPEC: assert property (@(posedge sys_clk) disable iff (reset)
    ld_gspec |-> octet_w[6:3] == 4'h0 && octet_w[7] == gpermit) // R16
    else $error("gts spec octet wrong");
  AST_GTS_SKIP: assert property (@(posedge sys_clk) disable iff (reset)
    ld_gspec && gcnt == 3'h0 |=> st_reg == bff_pkg::ST_PSPEC) // R17
    else $error("gts fields not skipped");
  AST_PEND_SPEC: assert property (@(posedge sys_clk) disable iff (reset)
    load_ok && st_reg == bff_pkg::ST_PSPEC |-> octet_w[3] == 1'b0 && octet_w[7] == 1'b0
    && {1'b0, octet_w[2:0]} + {1'b0, octet_w[6:4]} <= 4'h7) // R23
    else $error("pending spec octet wrong");
  AST_FCS_FIRST: assert property (@(posedge sys_clk) disable iff (reset)
    load_ok && st_reg == bff_pkg::ST_FCS && cnt_reg == 6'd0 |=> ##1 tx_bit_valid && tx_bit == $past(crc_reg[15], 1)) // R5
    else $error("check value not sent r0 first");
  AST_RX_BAD: assert property (@(posedge sys_clk) disable iff (reset)
    rx_frame_end && rx_crc_reg != 16'h0000 |=> rx_bad_reg ##1 (rx_bad_reg || $past(rx_clr))) // R25
    else $error("bad frame not flagged");
  COV_TX_GTS: cover property (@(posedge sys_clk) disable iff (reset) ld_gspec && gcnt != 3'h0 ##[1:400] tx_frame_end);
  COV_TX_PAY: cover property (@(posedge sys_clk) disable iff (reset) tx_in_ready && tx_in_last && st_reg == bff_pkg::ST_PAY);
  COV_RX_GOOD: cover property (@(posedge sys_clk) disable iff (reset) rx_frame_end && rx_ok);
  COV_RX_BAD: cover property (@(posedge sys_clk) disable iff (reset) rx_frame_end && !rx_ok);
endmodule

// file: sim/bff_phy_model.sv
`timescale 1ns/1ps
module bff_phy_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  input wire logic tx_frame_end,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic rx_frame_end
);
  logic [7:0] cap [0:63];
  logic [7:0] sh;
  int nbits;
  int ncap;
  logic done;
  initial
  begin
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
    rx_frame_end = 1'b0;
  end
  // octets rebuilt lsb first as they arrive
  always @(posedge sys_clk)
  begin
    if (reset)
      restart();
    else if (tx_bit_valid)
    begin
      sh = {tx_bit, sh[7:1]};
      nbits++;
      if (nbits % 8 == 0)
      begin
        cap[ncap] = sh;
        ncap++;
      end
    end
    if (!reset && tx_frame_end)
      done = 1'b1;
  end
  task restart;
    ncap = 0;
    nbits = 0;
    done = 1'b0;
  endtask
  // replays the captured frame; idle line shows the inverse so a stale bit is never mistaken
  task automatic send(input int n, input int flip);
    for (int i = 0; i < n * 8; i++)
    begin
      @(posedge sys_clk);
      rx_bit <= cap[i / 8][i % 8] ^ (i == flip);
      rx_bit_valid <= 1'b1;
    end
    @(posedge sys_clk);
    rx_bit <= ~rx_bit;
    rx_bit_valid <= 1'b0;
    rx_frame_end <= 1'b1;
    @(posedge sys_clk);
    rx_frame_end <= 1'b0;
  endtask
endmodule

// file: sim/beacon_frame_fcs_framer_bench.sv
`timescale 1ns/1ps
module beacon_frame_fcs_framer_bench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] tx_in_data = 8'h00;
  logic tx_in_valid = 1'b0;
  logic tx_in_last = 1'b0;
  logic tx_in_ready, tx_bit, tx_bit_valid, tx_frame_end, rx_bit, rx_bit_valid, rx_frame_end;
  logic [7:0] ef [0:31];
  logic [7:0] sq [$];
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  bff_framer dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_in_data(tx_in_data),
    .tx_in_valid(tx_in_valid), .tx_in_last(tx_in_last), .tx_in_ready(tx_in_ready), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid), .tx_frame_end(tx_frame_end), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .rx_frame_end(rx_frame_end));
  bff_phy_model phy (.sys_clk(sys_clk), .reset(reset), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .tx_frame_end(tx_frame_end), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_frame_end(rx_frame_end));
  always #20 sys_clk = ~sys_clk;
  // stream source: next octet lands right after the edge that took the previous one
  always @(posedge sys_clk)
  begin
    if (tx_in_valid && tx_in_ready)
      sq.delete(0);
    tx_in_valid <= sq.size() != 0;
    tx_in_data <= sq.size() != 0 ? sq[0] : 8'h00;
    tx_in_last <= sq.size() == 1;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      conclude();
    end
  end
  task conclude;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // reflected form of x^16+x^12+x^5+1, zero start, no final inversion
  function automatic logic [15:0] crc(input int n);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < n * 8; i++)
      c = (c[0] ^ ef[i / 8][i % 8]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction
  task automatic load(input logic [191:0] v, input int n);
    for (int i = 0; i < n; i++)
      ef[i] = v[8 * (n - 1 - i) +: 8];
  endtask
  task automatic run_tx(input int n);
    logic [15:0] c;
    int t;
    c = crc(n);
    ef[n] = c[7:0];
    ef[n + 1] = c[15:8];
    phy.restart();
    wr(8'h00, 32'h0000_0001);
    t = 0;
    while (!phy.done && t < 1000)
    begin
      @(posedge sys_clk);
      t++;
    end
    check("frame end", phy.done, 1'b1);
    check("octet count", phy.ncap, n + 2);
    for (int i = 0; i < n + 2; i++)
      check("octet", phy.cap[i], ef[i]);
  endtask
  task reg_reset;
    logic [31:0] s;
    rd(8'h08, s);
    check("cfg reset", s, 32'h0000_0002);
    rd(8'h0C, s);
    check("superframe reset", s, 32'h0000_0FFF);
    rd(8'hFC, s);
    check("unmapped", s, 32'h0000_0000);
  endtask
  // security asked with version zero, cap slot below minimum and no descriptors
  task tx_short;
    wr(8'h08, 32'h0000_0026);
    wr(8'h0C, 32'h0001_5523);
    wr(8'h10, 32'h0000_00A5);
    wr(8'h14, 32'hBEEF_1234);
    load(88'h1080A53412EFBE23588000, 11);
    run_tx(11);
  endtask
  // security with nonzero version, five header octets, one extended pending address, no payload
  task tx_sec;
    wr(8'h08, 32'h0000_214E);
    wr(8'h0C, 32'h0000_8A12);
    sq = '{8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8};
    load(192'h0890A53412EFBEA1A2A3A4A5128A0010B1B2B3B4B5B6B7B8, 24);
    run_tx(24);
  endtask
  // extended source, one descriptor, one pending short address, one payload octet
  task tx_gts;
    wr(8'h08, 32'h0001_0403);
    wr(8'h0C, 32'h0012_83FF);
    wr(8'h18, 32'h89AB_CDEF);
    wr(8'h1C, 32'h0123_4567);
    wr(8'h20, 32'h0032_5678);
    sq = '{8'h11, 8'h22, 8'h33};
    load(192'h00C0A53412EFCDAB8967452301FF83010178563201112233, 24);
    run_tx(24);
  endtask
  task rx_check;
    logic [31:0] s;
    phy.send(26, -1);
    rd(8'h04, s);
    check("rx good", s[2:1], 2'b01);
    check("rx sequence", s[15:8], 8'hA5);
    check("rx control", s[21:16], 6'h30);
    wr(8'h00, 32'h0000_0002);
    phy.send(26, 100);
    rd(8'h04, s);
    check("rx bad", s[2:1], 2'b10);
  endtask
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    reg_reset();
    tx_short();
    tx_sec();
    tx_gts();
    rx_check();
    conclude();
  end
endmodule
